// file: hw/vesrp_link_sampler.sv
// Link-clock bit sampler: captures the data line on each serial clock rise
`timescale 1ns/1ps
module vesrp_link_sampler (
    // Link clock and reset
    input wire logic serial_clock_line,
    input wire logic rst,
    // Line level
    input wire logic serial_data_in,
    // Held bit and its event toggle
    output logic bit_value_r,
    output logic bit_toggle_r
);

    // ************************************************************
    // Bit capture
    // ************************************************************
    // The bit is held for a whole link period, so the system side can
    // read it safely once the toggle has crossed. Reset only takes a
    // constant, and the link clock is quiet while it is released.
    always_ff @(posedge serial_clock_line or posedge rst) begin
        if (rst) begin
            bit_value_r <= 1'b0;
            bit_toggle_r <= 1'b0;
        end else begin
            bit_value_r <= serial_data_in;
            bit_toggle_r <= ~bit_toggle_r;
        end
    end

endmodule

// file: hw/vesrp_pkg.sv
// Package: constants and types for the encoder serial register port
package vesrp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int REG_SLOTS = 33;
    localparam logic [5:0] REG_COUNT_FULL = 6'h21;
    localparam logic [5:0] REG_COUNT_LITE = 6'h13;
    localparam logic [4:0] IDX_MODE_A = 5'h00;
    localparam logic [4:0] IDX_MODE_B = 5'h01;
    localparam logic [4:0] IDX_FSC0 = 5'h02;
    localparam logic [4:0] IDX_FSC1 = 5'h03;
    localparam logic [4:0] IDX_FSC2 = 5'h04;
    localparam logic [4:0] IDX_FSC3 = 5'h05;
    localparam logic [4:0] IDX_TIMING0 = 5'h07;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [31:0] FSC_RESET = 32'h21f07c16;
    localparam logic [7:0] MODE_A_RESET = 8'h04;
    localparam logic [7:0] REG_CLEAR = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MA_STD_LSB = 0;
    localparam int MA_PED_BIT = 2;
    localparam int MA_LUMA_LSB = 3;
    localparam int MA_RGBSYNC_BIT = 5;
    localparam int MA_OUTFMT_BIT = 6;
    localparam int MB_INTL_BIT = 0;
    localparam int MB_CAP_LSB = 1;
    localparam int MB_DAC_LSB = 3;
    localparam int MB_BAR_BIT = 7;
    localparam int TM0_PIXEL_BIT = 6;
    localparam int SEL_MSB = 4;
    localparam int ADDR_PIN_BIT = 1;

    // ************************************************************
    // Field encodings (plain defaults)
    // ************************************************************
    localparam logic [1:0] STD_NTSC = 2'h0;
    localparam logic [1:0] STD_PAL_BDGHI = 2'h1;
    localparam logic [1:0] STD_PAL_M = 2'h2;
    localparam logic [1:0] STD_PAL_N = 2'h3;
    localparam logic OUTFMT_COMPOSITE = 1'b0;
    // Arbitrary fixed part of the slave address
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2a;

    // Colour bar levels in half-percent steps, four bars
    localparam logic [31:0] BAR_NTSC = 32'h9696960f;
    localparam logic [31:0] BAR_PAL = 32'hc8009600;

    // ************************************************************
    // Bit slot counts
    // ************************************************************
    localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SUB,
        ST_WR,
        ST_RD
    } vesrp_state_t;

endpackage

// file: hw/vesrp_top.sv
// Serial slave port and mode registers of a video encoder
//
// Operation
// - Reset pin falling edge resets, selects low pixels
// - Reset gives NTSC and subcarrier code 21F07C16
// - Other registers clear; mode A keeps pedestal set
// - Address byte: 7-bit address, then direction bit
// - Address bit one follows address select pin
// - Start is data fall with clock high
// - Bytes travel most significant bit first
// - Match acknowledges on ninth pulse; mismatch idles
// - Second byte is subaddress; pointer auto increments
// - Pointer range 33 or 19 by variant
// - Stray start restarts address phase; stray stop idles
// - Invalid subaddress: no acknowledge, go idle
// - Read past end repeats last register
// - Write past end discarded, not acknowledged, idle
// - All registers read/write; pointer write-only
// - Mode A: standard select, NTSC-only pedestal
// - Mode A: luma filter, RGB sync, output format
// - Mode B: interlace, caption field, DAC power-down
// - Mode B: colour bars, NTSC levels or PAL levels for all other standards
`timescale 1ns/1ps
module vesrp_top #(
    parameter logic [6:0] SLAVE_ADDR = vesrp_pkg::SLAVE_ADDR_DEFAULT,
    parameter bit COPY_PROTECT = 1'b1
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // External reset and address select pins
    input wire logic reset_pin_n,
    input wire logic address_select_pin,
    // Two-wire serial link
    input wire logic serial_clock_line,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    // Mode register A fields
    output logic [1:0] encode_standard_field,
    output logic pedestal_enable_bit,
    output logic pedestal_active,
    output logic [1:0] luma_filter_select,
    output logic rgb_sync_enable,
    output logic output_format_select,
    // Mode register B fields
    output logic interlace_select,
    output logic interlace_active,
    output logic [1:0] caption_field_select,
    output logic [3:0] dac_powerdown_field,
    output logic color_bar_enable,
    output logic [31:0] color_bar_levels,
    // Other register views
    output logic [31:0] subcarrier_freq,
    output logic low_pixel_inputs_select
);
    import vesrp_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic rstp_s1_r, rstp_s2_r, rstp_s3_r;
    logic asel_s1_r, asel_s2_r;
    logic tog_s1_r, tog_s2_r, tog_seen_r;
    logic bit_value, bit_toggle;
    logic [7:0] regs_r [REG_SLOTS];
    vesrp_state_t state_r, state_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic [5:0] ptr_r, ptr_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic ack_r, ack_nxt;
    logic oe_r, oe_nxt;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Value a register takes at reset
    function automatic logic [7:0] reset_value(input int idx);
        logic [7:0] val;
        val = REG_CLEAR;
        case (idx)
            int'(IDX_MODE_A): val = MODE_A_RESET;
            int'(IDX_FSC0): val = FSC_RESET[7:0];
            int'(IDX_FSC1): val = FSC_RESET[15:8];
            int'(IDX_FSC2): val = FSC_RESET[23:16];
            int'(IDX_FSC3): val = FSC_RESET[31:24];
            default: val = REG_CLEAR;
        endcase
        return val;
    endfunction

    // Bit of a byte to send at a given slot, first slot is the MSB
    function automatic logic slot_bit(input logic [7:0] byte_in, input logic [3:0] slot);
        logic [3:0] pos;
        pos = LAST_DATA_SLOT - slot;
        return byte_in[pos[2:0]];
    endfunction

    // ************************************************************
    // Link-clock bit sampler
    // ************************************************************
    vesrp_link_sampler u_sampler (
        .serial_clock_line(serial_clock_line),
        .rst(rst),
        .serial_data_in(serial_data_in),
        .bit_value_r(bit_value),
        .bit_toggle_r(bit_toggle)
    );

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Two flops before use; third stage feeds edge detectors and the clock-high check
    always_ff @(posedge clk) begin
        scl_s1_r <= serial_clock_line;
        scl_s2_r <= scl_s1_r;
        scl_s3_r <= scl_s2_r;
        sda_s1_r <= serial_data_in;
        sda_s2_r <= sda_s1_r;
        sda_s3_r <= sda_s2_r;
        rstp_s1_r <= reset_pin_n;
        rstp_s2_r <= rstp_s1_r;
        rstp_s3_r <= rstp_s2_r;
        asel_s1_r <= address_select_pin;
        asel_s2_r <= asel_s1_r;
        tog_s1_r <= bit_toggle;
        tog_s2_r <= tog_s1_r;
    end

    // ************************************************************
    // Event decode
    // ************************************************************
    wire pin_reset_fall = rstp_s3_r & ~rstp_s2_r;
    wire soft_rst = rst | pin_reset_fall;
    wire scl_fall = scl_s3_r & ~scl_s2_r;
    wire scl_high = scl_s2_r & scl_s3_r;
    wire start_det = scl_high & sda_s3_r & ~sda_s2_r;
    wire stop_det = scl_high & ~sda_s3_r & sda_s2_r;
    // Bit value is held a full link period, safe after the toggle
    wire bit_evt = (tog_s2_r ^ tog_seen_r) & (state_r != ST_IDLE);
    wire [7:0] rx_byte = {rx_r[6:0], bit_value};
    wire byte_done = bit_evt & (bitcnt_r == LAST_DATA_SLOT);
    wire ack_rise = bit_evt & (bitcnt_r == ACK_SLOT);

    // ************************************************************
    // Address and pointer decode
    // ************************************************************
    wire [6:0] own_addr = {SLAVE_ADDR[6:2], asel_s2_r, SLAVE_ADDR[0]};
    wire addr_hit = (rx_byte[7:1] == own_addr);
    wire dir_read = rx_byte[0];
    wire [5:0] reg_count = COPY_PROTECT ? REG_COUNT_FULL : REG_COUNT_LITE;
    wire [5:0] last_ptr = reg_count - 6'h01;
    wire sub_ok = (rx_byte < {2'b00, reg_count});
    wire ptr_ok = (ptr_r < reg_count);
    wire wr_en = byte_done & (state_r == ST_WR) & ptr_ok;
    wire [7:0] read_data = ptr_ok ? regs_r[ptr_r] : regs_r[last_ptr];

    // ************************************************************
    // Protocol next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        ptr_nxt = ptr_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        ack_nxt = ack_r;
        oe_nxt = oe_r;
        // Bit slots: eight data bits then the acknowledge slot
        if (bit_evt && bitcnt_r < ACK_SLOT) begin
            rx_nxt = rx_byte;
            bitcnt_nxt = bitcnt_r + 4'h1;
        end
        if (ack_rise) begin
            bitcnt_nxt = ACK_DONE;
        end
        case (state_r)
            ST_IDLE: begin
                ack_nxt = 1'b0;
            end
            ST_ADDR: begin
                if (byte_done) begin
                    ack_nxt = addr_hit;
                    if (!addr_hit) begin
                        state_nxt = ST_IDLE;
                    end else if (dir_read) begin
                        state_nxt = ST_RD;
                    end else begin
                        state_nxt = ST_SUB;
                    end
                end
            end
            ST_SUB: begin
                if (byte_done) begin
                    ack_nxt = sub_ok;
                    if (sub_ok) begin
                        ptr_nxt = rx_byte[5:0];
                        state_nxt = ST_WR;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_WR: begin
                if (byte_done) begin
                    ack_nxt = ptr_ok;
                    if (ptr_ok) begin
                        ptr_nxt = ptr_r + 6'h01;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_RD: begin
                // Master answers after each read byte; high ends the read
                if (ack_rise && !ack_r) begin
                    if (bit_value) begin
                        state_nxt = ST_IDLE;
                    end else if (ptr_r < last_ptr) begin
                        ptr_nxt = ptr_r + 6'h01;
                    end else begin
                        ptr_nxt = last_ptr;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Line drive changes only while the clock is low
        if (scl_fall) begin
            if (bitcnt_r == ACK_SLOT) begin
                oe_nxt = ack_r;
            end else if (bitcnt_r == ACK_DONE) begin
                bitcnt_nxt = 4'h0;
                ack_nxt = 1'b0;
                if (state_nxt == ST_RD) begin
                    tx_nxt = read_data;
                    oe_nxt = ~read_data[7];
                end else begin
                    oe_nxt = 1'b0;
                end
            end else if (state_r == ST_RD) begin
                oe_nxt = ~slot_bit(tx_r, bitcnt_r);
            end else begin
                oe_nxt = 1'b0;
            end
        end
        // Start and stop win at any point of a transfer
        if (start_det) begin
            state_nxt = ST_ADDR;
            bitcnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            oe_nxt = 1'b0;
        end else if (stop_det) begin
            state_nxt = ST_IDLE;
            ack_nxt = 1'b0;
            oe_nxt = 1'b0;
        end
    end

    // ************************************************************
    // Protocol registers
    // ************************************************************
    // The seen copy follows the crossed toggle even under reset
    always_ff @(posedge clk) begin
        tog_seen_r <= tog_s2_r;
    end

    // Pin reset also drops any transfer in flight
    always_ff @(posedge clk) begin
        if (soft_rst) begin
            state_r <= ST_IDLE;
            bitcnt_r <= 4'h0;
            ptr_r <= 6'h00;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            ack_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            ptr_r <= ptr_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            ack_r <= ack_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // All slots exist; the lite variant simply never reaches the top
    always_ff @(posedge clk) begin
        if (soft_rst) begin
            for (int i = 0; i < REG_SLOTS; i++) begin
                regs_r[i] <= reset_value(i);
            end
        end else if (wr_en) begin
            regs_r[ptr_r] <= rx_byte;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Open-drain line: only ever pulls low
    assign serial_data_out = 1'b0;
    assign serial_data_oe = oe_r;

    // Mode register A
    assign encode_standard_field = regs_r[IDX_MODE_A][MA_STD_LSB +: 2];
    assign pedestal_enable_bit = regs_r[IDX_MODE_A][MA_PED_BIT];
    // Pedestal means nothing outside NTSC
    assign pedestal_active = pedestal_enable_bit & (encode_standard_field == STD_NTSC);
    assign luma_filter_select = regs_r[IDX_MODE_A][MA_LUMA_LSB +: 2];
    assign rgb_sync_enable = regs_r[IDX_MODE_A][MA_RGBSYNC_BIT];
    assign output_format_select = regs_r[IDX_MODE_A][MA_OUTFMT_BIT];

    // Mode register B
    assign interlace_select = regs_r[IDX_MODE_B][MB_INTL_BIT];
    // Interlace choice only counts in composite mode
    assign interlace_active = interlace_select & (output_format_select == OUTFMT_COMPOSITE);
    assign caption_field_select = regs_r[IDX_MODE_B][MB_CAP_LSB +: 2];
    assign dac_powerdown_field = regs_r[IDX_MODE_B][MB_DAC_LSB +: 4];
    assign color_bar_enable = regs_r[IDX_MODE_B][MB_BAR_BIT];
    wire [31:0] bar_pick = (encode_standard_field == STD_NTSC) ? BAR_NTSC : BAR_PAL;
    assign color_bar_levels = color_bar_enable ? bar_pick : 32'h00000000;

    // Subcarrier word and pixel port selection
    assign subcarrier_freq = {regs_r[IDX_FSC3], regs_r[IDX_FSC2],
                              regs_r[IDX_FSC1], regs_r[IDX_FSC0]};
    assign low_pixel_inputs_select = ~regs_r[IDX_TIMING0][TM0_PIXEL_BIT];

endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the encoder serial register port
`timescale 1ns/1ps
module tb_top;
    import vesrp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic address_select_pin = 1'b0;
    wire logic scl;
    wire logic sda_lo;
    wire logic sda;
    logic sd_out, sd_oe, ped_b, ped_a, rgb_b, fmt_b, intl_b, intl_a, bar_b, lowpix;
    logic [1:0] std_f, luma_f, cap_f;
    logic [3:0] dac_f;
    logic [31:0] bar_lv, fsc;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] rd [$];
    logic [15:0] acks;
    wire [17:0] stat = {std_f, ped_b, ped_a, luma_f, rgb_b, fmt_b, intl_b, intl_a, cap_f,
        dac_f, bar_b, lowpix};

    // Pull-up: a released line reads high
    assign sda = ~(sd_oe | sda_lo);

    // Clock and watchdog
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #300000;
        mismatches++;
        report_and_stop();
    end

    vesrp_top DUT (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
        .address_select_pin(address_select_pin), .serial_clock_line(scl),
        .serial_data_in(sda), .serial_data_out(sd_out), .serial_data_oe(sd_oe),
        .encode_standard_field(std_f), .pedestal_enable_bit(ped_b), .pedestal_active(ped_a),
        .luma_filter_select(luma_f), .rgb_sync_enable(rgb_b), .output_format_select(fmt_b),
        .interlace_select(intl_b), .interlace_active(intl_a), .caption_field_select(cap_f),
        .dac_powerdown_field(dac_f), .color_bar_enable(bar_b), .color_bar_levels(bar_lv),
        .subcarrier_freq(fsc), .low_pixel_inputs_select(lowpix));

    vesrp_master_model mst (.sda(sda), .scl(scl), .sda_lo(sda_lo));

    // Address bit one comes from the pin, the rest from the fixed part
    function automatic logic [6:0] dev_addr(input logic pin);
        return {SLAVE_ADDR_DEFAULT[6:2], pin, SLAVE_ADDR_DEFAULT[0]};
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Link phase kept off the system clock edges
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
        #1.3;
    endtask

    // Write frame; acks bit k is the answer to byte k
    task automatic xw(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d[$]);
        logic k;
        acks = '0;
        mst.start_c();
        mst.wr_byte({a, 1'b0}, k);
        acks[0] = k;
        mst.wr_byte(sub, k);
        acks[1] = k;
        foreach (d[j]) begin
            mst.wr_byte(d[j], k);
            acks[j + 2] = k;
        end
        mst.stop_c();
        idle(10);
    endtask

    // Set pointer, repeated start, read n bytes, last one not acknowledged
    task automatic xr(input logic [7:0] sub, input int n);
        logic k;
        logic [7:0] b;
        rd.delete();
        mst.start_c();
        mst.wr_byte({dev_addr(address_select_pin), 1'b0}, k);
        mst.wr_byte(sub, k);
        mst.start_c();
        mst.wr_byte({dev_addr(address_select_pin), 1'b1}, k);
        for (int j = 0; j < n; j++) begin
            mst.rd_byte(j < n - 1, b);
            rd.push_back(b);
        end
        mst.stop_c();
        idle(10);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0] m0, m1;
        logic [1:0] s;
        logic k;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        idle(20);
        chk("fsc_rst", FSC_RESET, fsc);
        chk("stat_rst", 18'h0c001, stat);
        xr(8'h00, 2);
        chk("rd_rst", {MODE_A_RESET, REG_CLEAR}, {rd[0], rd[1]});
        // Every standard, both pin levels, one burst from register zero each
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            @(negedge clk);
            address_select_pin = s[0];
            idle(10);
            m0 = {1'b0, s[0], s[1], s, 1'b1, s};
            m1 = {1'b1, 4'(1 << i), s, ~s[0]};
            xw(dev_addr(s[0]), 8'h00, '{m0, m1, 8'h10 + 8'(i), 8'h20 + 8'(i), 8'h30 + 8'(i),
                8'h40 + 8'(i), 8'h00, s[0] ? 8'h40 : 8'h00});
            chk("acks", 16'h03ff, acks);
            chk("fields", {s, 1'b1, s == STD_NTSC, s, s[1], s[0], ~s[0], ~s[0], s, 4'(1 << i),
                1'b1, ~s[0]}, stat);
            chk("bars", (s == STD_NTSC) ? BAR_NTSC : BAR_PAL, bar_lv);
            chk("fsc", {8'h40 + 8'(i), 8'h30 + 8'(i), 8'h20 + 8'(i), 8'h10 + 8'(i)}, fsc);
            xw(dev_addr(~s[0]), 8'h01, '{8'h00});
            chk("foreign", 16'h0000, acks);
            xr(8'h00, 2);
            chk("rdback", {m0, m1}, {rd[0], rd[1]});
        end
        // Last two registers, then one byte too many
        xw(dev_addr(1'b1), 8'h1f, '{8'h5a, 8'ha5, 8'h77});
        chk("end_wr", 16'h000f, acks);
        xr(8'h1f, 4);
        chk("end_rd", 32'h5aa5a5a5, {rd[0], rd[1], rd[2], rd[3]});
        xw(dev_addr(1'b1), 8'h21, '{8'h33});
        chk("bad_sub", 16'h0001, acks);
        // Stop in mid-byte must leave the register untouched
        mst.start_c();
        mst.wr_byte({dev_addr(1'b1), 1'b0}, k);
        mst.wr_byte(8'h01, k);
        repeat (4) mst.put_bit(1'b0);
        mst.stop_c();
        idle(10);
        xr(8'h01, 1);
        chk("stray", m1, rd[0]);
        // Reset pin pulse
        @(negedge clk);
        reset_pin_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_pin_n = 1'b1;
        idle(10);
        chk("pin_fsc", FSC_RESET, fsc);
        chk("pin_stat", 18'h0c001, stat);
        report_and_stop();
    end
endmodule

// file: testbench/vesrp_master_model.sv
// Two-wire bus master model: 160 ns clock, idle high between frames
`timescale 1ns/1ps
module vesrp_master_model (
    // Wire level with pull-up
    input wire logic sda,
    // Driven clock and pull-low request
    output logic scl,
    output logic sda_lo
);
    // Clock stands high outside frames
    initial begin
        sda_lo = 1'b0;
        #1 scl = 1'b1; // Edge resets the sampler
    end

    // One bit, data set mid-low, held through the high phase
    task automatic put_bit(input logic b);
        #40 sda_lo = ~b;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
    endtask

    // Released line, sampled mid-high
    task automatic get_bit(output logic b);
        #40 sda_lo = 1'b0;
        #40 scl = 1'b1;
        #40 b = sda;
        #40 scl = 1'b0;
    endtask

    // Single start per clock high, also usable as repeated start
    task automatic start_c();
        #40 sda_lo = 1'b0;
        #40 scl = 1'b1;
        #40 sda_lo = 1'b1;
        #40 scl = 1'b0;
    endtask

    // Single stop per clock high, clock left high
    task automatic stop_c();
        #40 sda_lo = 1'b1;
        #40 scl = 1'b1;
        #40 sda_lo = 1'b0;
        #80;
    endtask

    // Byte out, most significant bit first, then acknowledge slot
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(nak);
        ack = ~nak;
    endtask

    // Byte in, then acknowledge or not-acknowledge from the master
    task automatic rd_byte(input logic ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(~ack);
    endtask
endmodule

// file: testbench/vesrp_top_checker.sv
// Assertion checker bound to the encoder serial register port
`timescale 1ns/1ps
module vesrp_top_checker (
    // Clock, reset and reset pin
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    // Link lines
    input wire logic serial_clock_line,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    // Register views
    input wire logic [1:0] encode_standard_field,
    input wire logic pedestal_enable_bit,
    input wire logic pedestal_active,
    input wire logic output_format_select,
    input wire logic interlace_select,
    input wire logic interlace_active,
    input wire logic color_bar_enable,
    input wire logic [31:0] color_bar_levels,
    input wire logic [31:0] subcarrier_freq,
    input wire logic low_pixel_inputs_select
);
    import vesrp_pkg::*;

    // ************************************************************
    // Reset values
    // ************************************************************
    // No disable here: these look at the cycle right after reset
    property p_rst_fsc;
        @(posedge clk) rst |=> subcarrier_freq == FSC_RESET;
    endproperty
    a_rst_fsc: assert property (p_rst_fsc)
        else $error("subcarrier code missing after reset");
    property p_rst_mode;
        @(posedge clk) rst |=> encode_standard_field == STD_NTSC && pedestal_enable_bit
            && !color_bar_enable && low_pixel_inputs_select;
    endproperty
    a_rst_mode: assert property (p_rst_mode)
        else $error("mode or pixel select wrong after reset");
    property p_rst_oe;
        @(posedge clk) rst |=> !serial_data_oe;
    endproperty
    a_rst_oe: assert property (p_rst_oe)
        else $error("data line held during reset");
    // Pin reset lands a few cycles after the pin falls
    property p_pin_rst;
        @(posedge clk) disable iff (rst)
            $fell(reset_pin_n) |-> ##[1:8] (subcarrier_freq == FSC_RESET && pedestal_enable_bit);
    endproperty
    a_pin_rst: assert property (p_pin_rst)
        else $error("reset pin fall did not reset registers");

    // ************************************************************
    // Link and field relations
    // ************************************************************
    property p_od;
        @(posedge clk) disable iff (rst) serial_data_out == 1'b0;
    endproperty
    a_od: assert property (p_od)
        else $error("data output not open drain");
    // Acknowledge and read bits only start while the clock is low
    property p_ack_low;
        @(posedge clk) disable iff (rst) $rose(serial_data_oe) |-> !serial_clock_line;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("data drive began with clock high");
    property p_ped;
        @(posedge clk) disable iff (rst)
            pedestal_active == (pedestal_enable_bit && encode_standard_field == STD_NTSC);
    endproperty
    a_ped: assert property (p_ped)
        else $error("pedestal active outside its standard");
    property p_intl;
        @(posedge clk) disable iff (rst)
            interlace_active == (interlace_select && output_format_select == OUTFMT_COMPOSITE);
    endproperty
    a_intl: assert property (p_intl)
        else $error("interlace active outside composite");
    property p_bars;
        @(posedge clk) disable iff (rst) color_bar_levels == (!color_bar_enable ? 32'h0 :
            (encode_standard_field == STD_NTSC ? BAR_NTSC : BAR_PAL));
    endproperty
    a_bars: assert property (p_bars)
        else $error("colour bar levels wrong");
endmodule

bind vesrp_top vesrp_top_checker u_chk (
    .clk(clk),
    .rst(rst),
    .reset_pin_n(reset_pin_n),
    .serial_clock_line(serial_clock_line),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .encode_standard_field(encode_standard_field),
    .pedestal_enable_bit(pedestal_enable_bit),
    .pedestal_active(pedestal_active),
    .output_format_select(output_format_select),
    .interlace_select(interlace_select),
    .interlace_active(interlace_active),
    .color_bar_enable(color_bar_enable),
    .color_bar_levels(color_bar_levels),
    .subcarrier_freq(subcarrier_freq),
    .low_pixel_inputs_select(low_pixel_inputs_select)
);
